// ===== logic/sisf_unit.sv
`timescale 1ns/1ps
module sisf_unit
#(
  parameter int LEVEL_BITS = sisf_pkg::LEVEL_BITS_DEF
)
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CE,
  input wire logic REAL_MODE,
  input wire logic [31:0] TABLE_BASE,
  input wire logic LD_VALID,
  input wire logic [2:0] LD_SEL,
  input wire logic [31:0] LD_DATA,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire sisf_pkg::sisf_op_t CMD_OP,
  input wire logic [7:0] CMD_VECTOR,
  input wire logic [15:0] CMD_STORAGE,
  input wire logic [7:0] CMD_LEVEL,
  input wire logic [31:0] CMD_OPERAND,
  input wire logic [31:0] CMD_BOUND_ADDR,
  input wire logic CMD_HAS_ERR,
  input wire logic [31:0] CMD_ERR_CODE,
  output logic CMD_DONE,
  output logic VEC_TAKEN,
  output logic [7:0] VEC_NUM,
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic MEM_STACK_SEG,
  output logic [31:0] MEM_ADDR,
  output logic [31:0] MEM_WDATA,
  input wire logic MEM_ACK,
  input wire logic [31:0] MEM_RDATA,
  output logic TASK_REQ,
  output logic TASK_RETURN,
  output logic [15:0] TASK_SEL,
  input wire logic TASK_ACK,
  output logic [31:0] FLAGS,
  output logic [31:0] IP,
  output logic [15:0] CS,
  output logic [31:0] SP,
  output logic [31:0] BP
);
  import sisf_pkg::*;

  generate
    if (LEVEL_BITS < 1 || LEVEL_BITS > 8)
    begin : g_bad_level
      $error("LEVEL_BITS must lie between 1 and 8");
    end
  endgenerate

  typedef enum
  {
    ST_IDLE, ST_BND_LO, ST_BND_HI, ST_CHECK, ST_TBL0, ST_TBL1, ST_TASK,
    ST_PUSH_FL, ST_PUSH_CS, ST_PUSH_IP, ST_PUSH_ERR, ST_JUMP,
    ST_POP_IP, ST_POP_CS, ST_POP_FL,
    ST_EN_BP, ST_EN_RD, ST_EN_WR, ST_EN_FT, ST_EN_ALLOC,
    ST_LV_POP, ST_DONE
  } sisf_state_t;

  sisf_state_t state_q;
  sisf_op_t op_q;
  logic [31:0] flags_q, ip_q, sp_q, bp_q;
  logic [15:0] cs_q;
  logic [7:0] vec_raw_q, vec_num_q;
  logic vec_taken_q;
  logic [15:0] storage_q;
  logic [LEVEL_BITS-1:0] level_q, cnt_q;
  logic [31:0] operand_q, bnd_addr_q, bnd_lo_q, bnd_hi_q;
  logic has_err_q;
  logic [31:0] err_q;
  logic [31:0] hnd_ip_q;
  logic [15:0] hnd_cs_q;
  logic int_gate_q;
  logic [31:0] frame_q, walk_q, copy_q;
  logic task_req_q, task_ret_q;
  logic mem_req_q, mem_we_q, mem_stk_q;
  logic [31:0] mem_addr_q, mem_wdata_q;
  logic mem_we_d, mem_stk_d;
  logic [31:0] mem_addr_d, mem_wdata_d;
  logic mem_done;
  logic dec_take;
  logic [7:0] dec_vec;

  function automatic logic uses_mem(input sisf_state_t s);
    case (s)
      ST_BND_LO, ST_BND_HI, ST_TBL0, ST_TBL1,
      ST_PUSH_FL, ST_PUSH_CS, ST_PUSH_IP, ST_PUSH_ERR,
      ST_POP_IP, ST_POP_CS, ST_POP_FL,
      ST_EN_BP, ST_EN_RD, ST_EN_WR, ST_EN_FT, ST_LV_POP: uses_mem = 1'b1;
      default: uses_mem = 1'b0;
    endcase
  endfunction

  sisf_trap_decode u_decode
  (
    .op(op_q),
    .vector_in(vec_raw_q),
    .of_flag(flags_q[FLAG_OF_POS]),
    .bnd_val(operand_q),
    .bnd_lo(bnd_lo_q),
    .bnd_hi(bnd_hi_q),
    .take(dec_take),
    .vector(dec_vec)
  );

  assign mem_done = mem_req_q && MEM_ACK;
  // Loads win over commands so the core can seed state before a sequence
  assign CMD_READY = (state_q == ST_IDLE) && !LD_VALID;
  assign CMD_DONE = (state_q == ST_DONE);

  // Address and data of the access the current state needs
  always_comb
  begin
    mem_addr_d = sp_q - SLOT_BYTES;
    mem_wdata_d = 32'h0000_0000;
    mem_we_d = 1'b0;
    mem_stk_d = 1'b1;
    case (state_q)
      ST_BND_LO:
      begin
        mem_addr_d = bnd_addr_q;
        mem_stk_d = 1'b0;
      end
      ST_BND_HI:
      begin
        mem_addr_d = bnd_addr_q + ENTRY_HI_OFS;
        mem_stk_d = 1'b0;
      end
      ST_TBL0:
      begin
        // Real mode entries are one dword, protected gates two
        mem_addr_d = REAL_MODE ? TABLE_BASE + {22'h0, vec_num_q, 2'b00}
                               : TABLE_BASE + {21'h0, vec_num_q, 3'b000};
        mem_stk_d = 1'b0;
      end
      ST_TBL1:
      begin
        mem_addr_d = TABLE_BASE + {21'h0, vec_num_q, 3'b000} + ENTRY_HI_OFS;
        mem_stk_d = 1'b0;
      end
      ST_PUSH_FL:
      begin
        mem_we_d = 1'b1;
        mem_wdata_d = flags_q;
      end
      ST_PUSH_CS:
      begin
        mem_we_d = 1'b1;
        mem_wdata_d = {16'h0000, cs_q};
      end
      ST_PUSH_IP:
      begin
        mem_we_d = 1'b1;
        mem_wdata_d = ip_q;
      end
      ST_PUSH_ERR:
      begin
        mem_we_d = 1'b1;
        mem_wdata_d = err_q;
      end
      ST_POP_IP, ST_POP_CS, ST_POP_FL:
      begin
        mem_addr_d = sp_q;
      end
      ST_EN_BP:
      begin
        mem_we_d = 1'b1;
        mem_wdata_d = bp_q;
      end
      ST_EN_RD:
      begin
        // Frame-base relative read, so it goes to the stack segment
        mem_addr_d = walk_q - SLOT_BYTES;
        mem_stk_d = 1'b1;
      end
      ST_EN_WR:
      begin
        mem_we_d = 1'b1;
        mem_wdata_d = copy_q;
      end
      ST_EN_FT:
      begin
        mem_we_d = 1'b1;
        mem_wdata_d = frame_q;
      end
      ST_LV_POP:
      begin
        mem_addr_d = bp_q;
      end
      default:
      begin
        mem_addr_d = sp_q - SLOT_BYTES;
      end
    endcase
  end

  // Memory port: one access at a time, held until acknowledged
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_stk_q <= 1'b0;
      mem_addr_q <= 32'h0000_0000;
      mem_wdata_q <= 32'h0000_0000;
    end
    else if (CE)
    begin
      if (mem_done)
      begin
        mem_req_q <= 1'b0;
      end
      else if (!mem_req_q && uses_mem(state_q))
      begin
        mem_req_q <= 1'b1;
        mem_we_q <= mem_we_d;
        mem_stk_q <= mem_stk_d;
        mem_addr_q <= mem_addr_d;
        mem_wdata_q <= mem_wdata_d;
      end
    end
  end

  // Sequencer and architectural registers
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      state_q <= ST_IDLE;
      op_q <= OP_NONE;
      flags_q <= FLAGS_RESET;
      ip_q <= 32'h0000_0000;
      cs_q <= 16'h0000;
      sp_q <= 32'h0000_0000;
      bp_q <= 32'h0000_0000;
      vec_raw_q <= 8'h00;
      vec_num_q <= 8'h00;
      vec_taken_q <= 1'b0;
      storage_q <= 16'h0000;
      level_q <= '0;
      cnt_q <= '0;
      operand_q <= 32'h0000_0000;
      bnd_addr_q <= 32'h0000_0000;
      bnd_lo_q <= 32'h0000_0000;
      bnd_hi_q <= 32'h0000_0000;
      has_err_q <= 1'b0;
      err_q <= 32'h0000_0000;
      hnd_ip_q <= 32'h0000_0000;
      hnd_cs_q <= 16'h0000;
      int_gate_q <= 1'b0;
      frame_q <= 32'h0000_0000;
      walk_q <= 32'h0000_0000;
      copy_q <= 32'h0000_0000;
      task_req_q <= 1'b0;
      task_ret_q <= 1'b0;
    end
    else if (CE)
    begin
      case (state_q)
        ST_IDLE:
        begin
          vec_taken_q <= 1'b0;
          if (LD_VALID)
          begin
            case (LD_SEL)
              LD_FLAGS: flags_q <= LD_DATA;
              LD_IP: ip_q <= LD_DATA;
              LD_CS: cs_q <= LD_DATA[15:0];
              LD_SP: sp_q <= LD_DATA;
              LD_BP: bp_q <= LD_DATA;
              default: flags_q <= flags_q;
            endcase
          end
          else if (CMD_VALID)
          begin
            op_q <= CMD_OP;
            vec_raw_q <= CMD_VECTOR;
            storage_q <= CMD_STORAGE;
            level_q <= CMD_LEVEL[LEVEL_BITS-1:0];
            operand_q <= CMD_OPERAND;
            bnd_addr_q <= CMD_BOUND_ADDR;
            has_err_q <= CMD_HAS_ERR;
            err_q <= CMD_ERR_CODE;
            case (CMD_OP)
              OP_SOFTWARE_INTERRUPT_INSTRUCTION, OP_INTO, OP_BREAKPOINT_TRAP_INSTRUCTION: state_q <= ST_CHECK;
              OP_BOUND: state_q <= ST_BND_LO;
              OP_INTERRUPT_RETURN_INSTRUCTION:
              begin
                if (!REAL_MODE && flags_q[FLAG_NT_POS])
                begin
                  task_req_q <= 1'b1;
                  task_ret_q <= 1'b1;
                  state_q <= ST_TASK;
                end
                else
                begin
                  state_q <= ST_POP_IP;
                end
              end
              OP_ENTER: state_q <= ST_EN_BP;
              OP_LEAVE: state_q <= ST_LV_POP;
              default: state_q <= ST_DONE;
            endcase
          end
        end
        ST_BND_LO:
        begin
          if (mem_done)
          begin
            bnd_lo_q <= MEM_RDATA;
            state_q <= ST_BND_HI;
          end
        end
        ST_BND_HI:
        begin
          if (mem_done)
          begin
            bnd_hi_q <= MEM_RDATA;
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK:
        begin
          vec_num_q <= dec_vec;
          state_q <= dec_take ? ST_TBL0 : ST_DONE;
        end
        ST_TBL0:
        begin
          if (mem_done)
          begin
            hnd_ip_q <= {16'h0000, MEM_RDATA[15:0]};
            hnd_cs_q <= MEM_RDATA[31:16];
            int_gate_q <= 1'b0;
            state_q <= REAL_MODE ? ST_PUSH_FL : ST_TBL1;
          end
        end
        ST_TBL1:
        begin
          if (mem_done)
          begin
            hnd_ip_q[31:16] <= MEM_RDATA[31:16];
            int_gate_q <= !MEM_RDATA[GATE_TYPE_LSB];
            if (MEM_RDATA[GATE_TYPE_MSB:GATE_TYPE_LSB] == GATE_TYPE_TASK)
            begin
              // The switcher saves and restores the complete task state
              task_req_q <= 1'b1;
              task_ret_q <= 1'b0;
              state_q <= ST_TASK;
            end
            else
            begin
              state_q <= ST_PUSH_FL;
            end
          end
        end
        ST_TASK:
        begin
          if (TASK_ACK)
          begin
            task_req_q <= 1'b0;
            vec_taken_q <= !task_ret_q;
            state_q <= ST_DONE;
          end
        end
        ST_PUSH_FL:
        begin
          if (mem_done)
          begin
            sp_q <= sp_q - SLOT_BYTES;
            state_q <= ST_PUSH_CS;
          end
        end
        ST_PUSH_CS:
        begin
          if (mem_done)
          begin
            sp_q <= sp_q - SLOT_BYTES;
            state_q <= ST_PUSH_IP;
          end
        end
        ST_PUSH_IP:
        begin
          if (mem_done)
          begin
            sp_q <= sp_q - SLOT_BYTES;
            state_q <= has_err_q ? ST_PUSH_ERR : ST_JUMP;
          end
        end
        ST_PUSH_ERR:
        begin
          if (mem_done)
          begin
            sp_q <= sp_q - SLOT_BYTES;
            state_q <= ST_JUMP;
          end
        end
        ST_JUMP:
        begin
          ip_q <= hnd_ip_q;
          cs_q <= hnd_cs_q;
          if (int_gate_q)
          begin
            flags_q[FLAG_IF_POS] <= 1'b0;
          end
          vec_taken_q <= 1'b1;
          state_q <= ST_DONE;
        end
        ST_POP_IP:
        begin
          if (mem_done)
          begin
            ip_q <= MEM_RDATA;
            sp_q <= sp_q + SLOT_BYTES;
            state_q <= ST_POP_CS;
          end
        end
        ST_POP_CS:
        begin
          if (mem_done)
          begin
            cs_q <= MEM_RDATA[15:0];
            sp_q <= sp_q + SLOT_BYTES;
            state_q <= ST_POP_FL;
          end
        end
        ST_POP_FL:
        begin
          if (mem_done)
          begin
            flags_q <= MEM_RDATA;
            sp_q <= sp_q + SLOT_BYTES;
            state_q <= ST_DONE;
          end
        end
        ST_EN_BP:
        begin
          if (mem_done)
          begin
            sp_q <= sp_q - SLOT_BYTES;
            frame_q <= sp_q - SLOT_BYTES;
            walk_q <= bp_q;
            cnt_q <= level_q - 1'b1;
            if (level_q == '0)
            begin
              state_q <= ST_EN_ALLOC;
            end
            else if (level_q == 1)
            begin
              state_q <= ST_EN_FT;
            end
            else
            begin
              state_q <= ST_EN_RD;
            end
          end
        end
        ST_EN_RD:
        begin
          if (mem_done)
          begin
            walk_q <= walk_q - SLOT_BYTES;
            copy_q <= MEM_RDATA;
            state_q <= ST_EN_WR;
          end
        end
        ST_EN_WR:
        begin
          if (mem_done)
          begin
            sp_q <= sp_q - SLOT_BYTES;
            cnt_q <= cnt_q - 1'b1;
            state_q <= (cnt_q == 1) ? ST_EN_FT : ST_EN_RD;
          end
        end
        ST_EN_FT:
        begin
          if (mem_done)
          begin
            sp_q <= sp_q - SLOT_BYTES;
            state_q <= ST_EN_ALLOC;
          end
        end
        ST_EN_ALLOC:
        begin
          bp_q <= frame_q;
          sp_q <= sp_q - {16'h0000, storage_q};
          state_q <= ST_DONE;
        end
        ST_LV_POP:
        begin
          if (mem_done)
          begin
            // Stack pointer takes the frame base, then the pop moves it past the slot
            sp_q <= bp_q + SLOT_BYTES;
            bp_q <= MEM_RDATA;
            state_q <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          state_q <= ST_IDLE;
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign VEC_TAKEN = vec_taken_q;
  assign VEC_NUM = vec_num_q;
  assign MEM_REQ = mem_req_q;
  assign MEM_WE = mem_we_q;
  assign MEM_STACK_SEG = mem_stk_q;
  assign MEM_ADDR = mem_addr_q;
  assign MEM_WDATA = mem_wdata_q;
  assign TASK_REQ = task_req_q;
  assign TASK_RETURN = task_ret_q;
  assign TASK_SEL = hnd_cs_q;
  assign FLAGS = flags_q;
  assign IP = ip_q;
  assign CS = cs_q;
  assign SP = sp_q;
  assign BP = bp_q;
endmodule

// ===== pkg/sisf_pkg.sv
package sisf_pkg;

  typedef enum logic [2:0]
  {
    OP_NONE,
    OP_SOFTWARE_INTERRUPT_INSTRUCTION,
    OP_INTO,
    OP_BREAKPOINT_TRAP_INSTRUCTION,
    OP_BOUND,
    OP_INTERRUPT_RETURN_INSTRUCTION,
    OP_ENTER,
    OP_LEAVE
  } sisf_op_t;

  localparam logic [7:0] VEC_BREAKPOINT = 8'h03;
  localparam logic [7:0] VEC_OVERFLOW = 8'h04;
  localparam logic [7:0] VEC_RANGE = 8'h05;

  localparam int FLAG_IF_POS = 9;
  localparam int FLAG_OF_POS = 11;
  localparam int FLAG_NT_POS = 14;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;

  localparam logic [31:0] SLOT_BYTES = 32'h0000_0004;
  localparam logic [31:0] ENTRY_HI_OFS = 32'h0000_0004;

  localparam int GATE_TYPE_LSB = 8;
  localparam int GATE_TYPE_MSB = 12;
  localparam logic [4:0] GATE_TYPE_TASK = 5'h05;

  localparam logic [2:0] LD_FLAGS = 3'h0;
  localparam logic [2:0] LD_IP = 3'h1;
  localparam logic [2:0] LD_CS = 3'h2;
  localparam logic [2:0] LD_SP = 3'h3;
  localparam logic [2:0] LD_BP = 3'h4;

  localparam int LEVEL_BITS_DEF = 5;

endpackage

// ===== logic/sisf_trap_decode.sv
`timescale 1ns/1ps
module sisf_trap_decode
(
  input wire sisf_pkg::sisf_op_t op,
  input wire logic [7:0] vector_in,
  input wire logic of_flag,
  input wire logic [31:0] bnd_val,
  input wire logic [31:0] bnd_lo,
  input wire logic [31:0] bnd_hi,
  output logic take,
  output logic [7:0] vector
);
  import sisf_pkg::*;

  logic out_of_range;

  // Bounds are signed, as array indices may be negative
  assign out_of_range = ($signed(bnd_val) < $signed(bnd_lo)) ||
                        ($signed(bnd_val) > $signed(bnd_hi));

  // Only these explicit instructions can raise a trap; no implicit checks exist
  always_comb
  begin
    take = 1'b0;
    vector = vector_in;
    case (op)
      OP_SOFTWARE_INTERRUPT_INSTRUCTION:
      begin
        take = 1'b1;
        vector = vector_in;
      end
      OP_INTO:
      begin
        take = of_flag;
        vector = VEC_OVERFLOW;
      end
      OP_BREAKPOINT_TRAP_INSTRUCTION:
      begin
        take = 1'b1;
        vector = VEC_BREAKPOINT;
      end
      OP_BOUND:
      begin
        take = out_of_range;
        vector = VEC_RANGE;
      end
      default:
      begin
        take = 1'b0;
        vector = vector_in;
      end
    endcase
  end
endmodule

// ===== tb/sisf_checker.sv
`timescale 1ns/1ps
module sisf_checker
#(
  parameter int LEVEL_BITS = sisf_pkg::LEVEL_BITS_DEF
)
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CE,
  input wire logic CMD_VALID,
  input wire logic CMD_READY,
  input wire sisf_pkg::sisf_op_t CMD_OP,
  input wire logic [7:0] CMD_VECTOR,
  input wire logic [15:0] CMD_STORAGE,
  input wire logic [7:0] CMD_LEVEL,
  input wire logic CMD_DONE,
  input wire logic VEC_TAKEN,
  input wire logic [7:0] VEC_NUM,
  input wire logic MEM_REQ,
  input wire logic MEM_WE,
  input wire logic MEM_STACK_SEG,
  input wire logic [31:0] MEM_ADDR,
  input wire logic [31:0] MEM_WDATA,
  input wire logic MEM_ACK,
  input wire logic TASK_REQ,
  input wire logic [15:0] TASK_SEL,
  input wire logic TASK_ACK,
  input wire logic [31:0] FLAGS,
  input wire logic [31:0] SP,
  input wire logic [31:0] BP
);
  import sisf_pkg::*;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  logic take;
  sisf_op_t op_q;
  logic [31:0] sp0_q;
  logic [31:0] bp0_q;
  logic [15:0] st_q;
  logic lvl0_q;
  assign take = CE && CMD_VALID && CMD_READY;
  // Snapshot at acceptance so end-of-command checks need no decode of the body
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      op_q <= OP_NONE;
      sp0_q <= 32'h0;
      bp0_q <= 32'h0;
      st_q <= 16'h0;
      lvl0_q <= 1'h0;
    end
    else if (take)
    begin
      op_q <= CMD_OP;
      sp0_q <= SP;
      bp0_q <= BP;
      st_q <= CMD_STORAGE;
      lvl0_q <= (CMD_LEVEL[LEVEL_BITS-1:0] == '0);
    end
  end
  into_clear_a:
    assert property (take && CMD_OP == OP_INTO && !FLAGS[FLAG_OF_POS] |->
      ##[1:4] (CMD_DONE && !VEC_TAKEN)) else $error("overflow trap without flag");
  into_vec_a:
    assert property (take && CMD_OP == OP_INTO && FLAGS[FLAG_OF_POS] |->
      ##2 (VEC_NUM == VEC_OVERFLOW)) else $error("overflow trap vector wrong");
  breakpoint_trap_instruction_vec_a:
    assert property (take && CMD_OP == OP_BREAKPOINT_TRAP_INSTRUCTION |-> ##2 (VEC_NUM == VEC_BREAKPOINT))
      else $error("breakpoint vector wrong");
  software_interrupt_instruction_vec_a:
    assert property (take && CMD_OP == OP_SOFTWARE_INTERRUPT_INSTRUCTION |-> ##2 (VEC_NUM == $past(CMD_VECTOR, 2)))
      else $error("software interrupt vector wrong");
  trap_only_a:
    assert property (CMD_DONE && VEC_TAKEN |->
      op_q inside {OP_SOFTWARE_INTERRUPT_INSTRUCTION, OP_INTO, OP_BREAKPOINT_TRAP_INSTRUCTION, OP_BOUND}) else $error("implicit trap");
  push_seg_a:
    assert property (MEM_REQ && MEM_WE |-> MEM_STACK_SEG) else $error("push off stack");
  mem_hold_a:
    assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) &&
      $stable(MEM_WDATA) && $stable(MEM_WE)) else $error("memory request moved");
  task_hold_a:
    assert property (TASK_REQ && !TASK_ACK |=> TASK_REQ && $stable(TASK_SEL))
      else $error("task switch request moved");
  flat_frame_a:
    assert property (CMD_DONE && op_q == OP_ENTER && lvl0_q |=> BP == sp0_q - 32'h4 &&
      SP == sp0_q - 32'h4 - {16'h0, st_q}) else $error("flat frame wrong");
  frame_drop_a:
    assert property (CMD_DONE && op_q == OP_LEAVE |=> SP == bp0_q + 32'h4)
      else $error("frame release wrong");
  cover property (take && CMD_OP == OP_ENTER && !CMD_LEVEL[0]);
  cover property (TASK_REQ && TASK_ACK);
  cover property (CMD_DONE && VEC_TAKEN);
endmodule
bind sisf_unit sisf_checker #(.LEVEL_BITS(LEVEL_BITS)) u_chk (.*);

// ===== tb/sisf_unit_bench.sv
`timescale 1ns/1ps
module sisf_unit_bench;
  import sisf_pkg::*;
  logic CLOCK, RST, CE, REAL_MODE, LD_VALID, CMD_VALID, CMD_HAS_ERR;
  logic MEM_ACK = 1'h0;
  logic TASK_ACK = 1'h0;
  logic [31:0] TABLE_BASE, LD_DATA, CMD_OPERAND, CMD_BOUND_ADDR, CMD_ERR_CODE;
  logic [31:0] MEM_RDATA = 32'h0;
  logic [2:0] LD_SEL;
  sisf_op_t CMD_OP;
  logic [7:0] CMD_VECTOR, CMD_LEVEL, VEC_NUM;
  logic [15:0] CMD_STORAGE, TASK_SEL, CS, m_cs, sv_cs, seen_sel;
  logic CMD_READY, CMD_DONE, VEC_TAKEN, MEM_REQ, MEM_WE, MEM_STACK_SEG, TASK_REQ, TASK_RETURN;
  logic [31:0] MEM_ADDR, MEM_WDATA, FLAGS, IP, SP, BP, m_fl, m_ip, m_sp, m_bp, sv_sp, sv_ip;
  logic [31:0] mem [logic [31:0]];
  logic [63:0] wr_q[$], ex_q[$];
  logic taken, seen_ret, rd_seg;
  int lv_tab[7] = '{0, 1, 2, 3, 5, 33, 31};
  logic [31:0] bnd_tab[4] = '{32'hffff_ffef, 32'hffff_fff0, 32'h0000_0010, 32'h0000_0011};
  int error_cnt, checked;
  sisf_unit #(.LEVEL_BITS(5)) DUT (.*);
  initial
  begin
    CLOCK = 1'h0;
    forever #10 CLOCK = ~CLOCK;
  end
  function automatic logic [31:0] rd(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : ~a;
  endfunction
  function automatic logic oob(input logic [31:0] x);
    return $signed(x) < $signed(mem[32'h2000]) || $signed(x) > $signed(mem[32'h2004]);
  endfunction
  // Memory side answers after a random stall; released read data is inverted
  always @(negedge CLOCK)
  begin
    if (MEM_ACK)
    begin
      MEM_ACK <= 1'h0;
      MEM_RDATA <= ~MEM_RDATA;
    end
    else if (MEM_REQ && $urandom_range(0, 2) == 0)
    begin
      MEM_ACK <= 1'h1;
      if (MEM_WE)
      begin
        mem[MEM_ADDR] = MEM_WDATA;
        wr_q.push_back({MEM_ADDR, MEM_WDATA});
      end
      else
      begin
        // Reads only, so handler pushes after a table read do not hide its segment
        rd_seg = MEM_STACK_SEG;
        MEM_RDATA <= rd(MEM_ADDR);
      end
    end
    if (TASK_ACK)
      TASK_ACK <= 1'h0;
    else if (TASK_REQ && $urandom_range(0, 3) == 0)
    begin
      TASK_ACK <= 1'h1;
      seen_sel = TASK_SEL;
      seen_ret = TASK_RETURN;
    end
  end
  task automatic final_report();
    if (error_cnt == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic push(input logic [31:0] d);
    m_sp = m_sp - SLOT_BYTES;
    // Deep display copies may read slots this same frame just pushed
    mem[m_sp] = d;
    ex_q.push_back({m_sp, d});
  endtask
  task automatic exp_int(input logic [7:0] v, input logic he);
    logic [31:0] ent;
    ent = rd(TABLE_BASE + {22'h0, v, 2'h0});
    push(m_fl);
    push({16'h0, m_cs});
    push(m_ip);
    if (he)
      push(CMD_ERR_CODE);
    m_ip = {16'h0, ent[15:0]};
    m_cs = ent[31:16];
  endtask
  task automatic exp_enter(input logic [15:0] st, input logic [7:0] lv);
    logic [31:0] fr;
    int l;
    l = int'(lv) % 32;
    push(m_bp);
    fr = m_sp;
    for (int i = 1; i < l; i++)
      push(rd(m_bp - 32'(4 * i)));
    if (l > 0)
      push(fr);
    m_bp = fr;
    m_sp = m_sp - {16'h0, st};
  endtask
  task automatic load(input logic [2:0] s, input logic [31:0] d);
    @(negedge CLOCK);
    LD_VALID = 1'h1;
    LD_SEL = s;
    LD_DATA = d;
    @(negedge CLOCK);
    LD_VALID = 1'h0;
  endtask
  task automatic run(input sisf_op_t op, input logic [7:0] v, input logic [15:0] st,
                     input logic [7:0] lv, input logic [31:0] opd, input logic he);
    int n;
    n = 0;
    wr_q.delete();
    @(negedge CLOCK);
    CMD_OP = op;
    CMD_VECTOR = v;
    CMD_STORAGE = st;
    CMD_LEVEL = lv;
    CMD_OPERAND = opd;
    CMD_HAS_ERR = he;
    CMD_VALID = 1'h1;
    @(negedge CLOCK);
    CMD_VALID = 1'h0;
    while (CMD_DONE !== 1'h1 && n < 1000)
    begin
      @(negedge CLOCK);
      n++;
    end
    if (n >= 1000)
    begin
      error_cnt++;
      $display("BAD %0t command hung", $time);
      final_report();
    end
    taken = VEC_TAKEN;
    @(negedge CLOCK);
  endtask
  task automatic chk_state(input logic vt, input logic [7:0] vn);
    chk(64'(wr_q.size()), 64'(ex_q.size()), "push count");
    foreach (ex_q[i])
      chk(wr_q[i], ex_q[i], "push");
    chk({SP, BP}, {m_sp, m_bp}, "sp bp");
    chk({IP, CS}, {m_ip, m_cs}, "ip cs");
    chk(FLAGS, m_fl, "flags");
    chk(taken, vt, "taken");
    if (vt)
      chk(VEC_NUM, vn, "vector");
    ex_q.delete();
  endtask
  initial
  begin
    logic [7:0] v;
    logic he;
    logic [31:0] x;
    void'($urandom(32'h8758));
    CE = 1'h1;
    RST = 1'h1;
    REAL_MODE = 1'h1;
    TABLE_BASE = 32'h0000_1000;
    LD_VALID = 1'h0;
    LD_SEL = 3'h0;
    LD_DATA = 32'h0;
    CMD_VALID = 1'h0;
    CMD_OP = OP_NONE;
    CMD_VECTOR = 8'h0;
    CMD_STORAGE = 16'h0;
    CMD_LEVEL = 8'h0;
    CMD_OPERAND = 32'h0;
    CMD_BOUND_ADDR = 32'h0000_2000;
    CMD_HAS_ERR = 1'h0;
    CMD_ERR_CODE = 32'h0;
    repeat (10) @(negedge CLOCK);
    RST = 1'h0;
    {m_sp, m_bp, m_ip, m_cs, m_fl} = {32'h8000, 32'h9000, 32'h100, 16'h40, FLAGS_RESET};
    load(LD_SP, m_sp);
    load(LD_BP, m_bp);
    load(LD_IP, m_ip);
    load(LD_CS, {16'h0, m_cs});
    repeat (6)
    begin
      v = 8'($urandom);
      he = 1'($urandom);
      CMD_ERR_CODE = $urandom;
      mem[TABLE_BASE + {22'h0, v, 2'h0}] = $urandom;
      {sv_sp, sv_ip, sv_cs} = {m_sp, m_ip, m_cs};
      exp_int(v, he);
      run(OP_SOFTWARE_INTERRUPT_INSTRUCTION, v, 16'h0, 8'h0, 32'h0, he);
      chk_state(1'h1, v);
      // The handler drops its error code before returning
      m_sp = m_sp + {29'h0, he, 2'h0};
      load(LD_SP, m_sp);
      {m_sp, m_ip, m_cs} = {sv_sp, sv_ip, sv_cs};
      run(OP_INTERRUPT_RETURN_INSTRUCTION, 8'h0, 16'h0, 8'h0, 32'h0, 1'h0);
      chk_state(1'h0, 8'h0);
    end
    exp_int(VEC_BREAKPOINT, 1'h0);
    run(OP_BREAKPOINT_TRAP_INSTRUCTION, 8'h0, 16'h0, 8'h0, 32'h0, 1'h0);
    chk_state(1'h1, VEC_BREAKPOINT);
    run(OP_INTO, 8'h0, 16'h0, 8'h0, 32'h0, 1'h0);
    chk_state(1'h0, 8'h0);
    m_fl = FLAGS_RESET | (32'h1 << FLAG_OF_POS);
    load(LD_FLAGS, m_fl);
    exp_int(VEC_OVERFLOW, 1'h0);
    run(OP_INTO, 8'h0, 16'h0, 8'h0, 32'h0, 1'h0);
    chk_state(1'h1, VEC_OVERFLOW);
    mem[32'h2000] = 32'hffff_fff0;
    mem[32'h2004] = 32'h0000_0010;
    for (int k = 0; k < 7; k++)
    begin
      x = (k < 4) ? bnd_tab[k] : 32'($urandom_range(0, 64)) - 32'h20;
      if (oob(x))
        exp_int(VEC_RANGE, 1'h0);
      run(OP_BOUND, 8'h0, 16'h0, 8'h0, x, 1'h0);
      chk_state(oob(x), VEC_RANGE);
      chk(rd_seg, 1'h0, "bound segment");
    end
    foreach (lv_tab[i])
    begin
      CMD_STORAGE = 16'($urandom_range(0, 255));
      exp_enter(CMD_STORAGE, 8'(lv_tab[i]));
      run(OP_ENTER, 8'h0, CMD_STORAGE, 8'(lv_tab[i]), 32'h0, 1'h0);
      chk_state(1'h0, 8'h0);
    end
    repeat (7)
    begin
      m_sp = m_bp + 32'h4;
      m_bp = rd(m_bp);
      run(OP_LEAVE, 8'h0, 16'h0, 8'h0, 32'h0, 1'h0);
      chk_state(1'h0, 8'h0);
      chk(rd_seg, 1'h1, "leave segment");
    end
    REAL_MODE = 1'h0;
    v = 8'($urandom);
    sv_cs = 16'($urandom);
    mem[TABLE_BASE + {21'h0, v, 3'h0}] = {sv_cs, 16'h0};
    mem[TABLE_BASE + {21'h0, v, 3'h4}] = {19'h0, GATE_TYPE_TASK, 8'h0};
    run(OP_SOFTWARE_INTERRUPT_INSTRUCTION, v, 16'h0, 8'h0, 32'h0, 1'h0);
    chk({taken, seen_ret, seen_sel}, {2'h2, sv_cs}, "task gate");
    load(LD_FLAGS, FLAGS_RESET | (32'h1 << FLAG_NT_POS));
    run(OP_INTERRUPT_RETURN_INSTRUCTION, 8'h0, 16'h0, 8'h0, 32'h0, 1'h0);
    chk(seen_ret, 1'h1, "task return");
    final_report();
  end
endmodule
